/* src/vlf_map.vh */
// Constants shared by the variable length sequence generator files
`ifndef VLF_MAP_VH
`define VLF_MAP_VH

// ==========================================================
// Widths
`define VLF_LEN_W 5
`define VLF_REG_W 32
`define VLF_SIZE_W 6
`define VLF_CNT_W 6

// ==========================================================
// Length limits and seeding
`define VLF_LEN_MIN 5'h01
`define VLF_LOAD_CYC 6'h20
`define VLF_RST_SEED 32'h00000001
`define VLF_ZERO_REG 32'h00000000
`define VLF_ONES_REG 32'hffffffff

// ==========================================================
// Feedback combining options
`define VLF_FB_XOR 1'b0
`define VLF_FB_XNOR 1'b1

`endif

/* src/vlf_skid.v */
// Two-entry skid buffer between the generator and its consumer
`timescale 1ns/1ps
module vlf_skid #(
  parameter WIDTH = 1
) (
  input wire sys_clk,            // System clock
  input wire arst,               // Asynchronous reset, active high
  input wire flush,              // Synchronous discard of both entries
  input wire in_valid,           // Producer offers a word
  output wire in_ready,          // Buffer can take a word
  input wire [WIDTH-1:0] in_data, // Word from producer
  output wire out_valid,         // Buffer offers a word
  input wire out_ready,          // Consumer takes the word
  output wire [WIDTH-1:0] out_data // Word to consumer
);

  reg [WIDTH-1:0] main_ff;
  reg [WIDTH-1:0] skid_ff;
  reg main_v_ff;
  reg skid_v_ff;

  // ==========================================================
  // Handshake
  // Ready depends only on a flop, so no path runs from out_ready
  assign in_ready = ~skid_v_ff;
  assign out_valid = main_v_ff;
  assign out_data = main_ff;

  // ==========================================================
  // Storage
  always @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      main_ff <= {WIDTH{1'b0}};
      skid_ff <= {WIDTH{1'b0}};
      main_v_ff <= 1'b0;
      skid_v_ff <= 1'b0;
    end else if (flush) begin
      main_v_ff <= 1'b0;
      skid_v_ff <= 1'b0;
    end else if (~main_v_ff | out_ready) begin
      if (skid_v_ff) begin
        main_ff <= skid_ff;
        main_v_ff <= 1'b1;
        skid_v_ff <= 1'b0;
      end else begin
        main_ff <= in_data;
        main_v_ff <= in_valid;
      end
    end else if (in_valid & ~skid_v_ff) begin
      // Consumer stalled: park the word rather than lose it
      skid_ff <= in_data;
      skid_v_ff <= 1'b1;
    end
  end

endmodule

/* src/vlf_lfsr.v */
// Variable length linear feedback sequence generator, 2 to 32 stages
`timescale 1ns/1ps
`include "vlf_map.vh"
module vlf_lfsr #(
  parameter FB_XNOR = `VLF_FB_XOR,
  parameter [`VLF_REG_W-1:0] RST_SEED = `VLF_RST_SEED
) (
  input wire sys_clk,                 // System clock, 100 MHz
  input wire arst,                    // Asynchronous reset, active high
  input wire [`VLF_LEN_W-1:0] seq_len, // Size minus one
  input wire load,                    // High: shift seed bits in
  input wire seed_in,                 // Serial seed bit
  output wire seq_valid,              // Sequence bit offered
  input wire seq_ready,               // Consumer takes the bit
  output wire seq_bit,                // Serial sequence output
  output wire [`VLF_SIZE_W-1:0] size_now, // Active stage count
  output wire load_done,              // 32 seed bits taken
  output wire load_short,             // Load ended before 32 bits
  output wire lock_state              // Register sits in lock-up value
);

  // ==========================================================
  // Decode helpers
  function [`VLF_REG_W-1:0] tap_mask;
    input [`VLF_LEN_W-1:0] len;
    begin
      case (len)
        5'h01: tap_mask = 32'h00000003;
        5'h02: tap_mask = 32'h00000006;
        5'h03: tap_mask = 32'h0000000c;
        5'h04: tap_mask = 32'h00000014;
        5'h05: tap_mask = 32'h00000030;
        5'h06: tap_mask = 32'h00000060;
        5'h07: tap_mask = 32'h000000b8;
        5'h08: tap_mask = 32'h00000110;
        5'h09: tap_mask = 32'h00000240;
        5'h0a: tap_mask = 32'h00000500;
        5'h0b: tap_mask = 32'h00000829;
        5'h0c: tap_mask = 32'h0000100d;
        5'h0d: tap_mask = 32'h00002015;
        5'h0e: tap_mask = 32'h00006000;
        5'h0f: tap_mask = 32'h0000d008;
        5'h10: tap_mask = 32'h00012000;
        5'h11: tap_mask = 32'h00020400;
        5'h12: tap_mask = 32'h00040023;
        5'h13: tap_mask = 32'h00090000;
        5'h14: tap_mask = 32'h00140000;
        5'h15: tap_mask = 32'h00300000;
        5'h16: tap_mask = 32'h00420000;
        5'h17: tap_mask = 32'h00e10000;
        5'h18: tap_mask = 32'h01200000;
        5'h19: tap_mask = 32'h02000023;
        5'h1a: tap_mask = 32'h04000013;
        5'h1b: tap_mask = 32'h09000000;
        5'h1c: tap_mask = 32'h14000000;
        5'h1d: tap_mask = 32'h20000029;
        5'h1e: tap_mask = 32'h48000000;
        5'h1f: tap_mask = 32'h80200003;
        default: tap_mask = 32'h00000003;
      endcase
    end
  endfunction

  // Ones over the active stages 0..len
  function [`VLF_REG_W-1:0] size_mask;
    input [`VLF_LEN_W-1:0] len;
    begin
      size_mask = ~(`VLF_ONES_REG << len) | (`VLF_ONES_REG << len
        & ~(`VLF_ONES_REG << len) );
      size_mask = {~(`VLF_ONES_REG << len)} | ({{`VLF_REG_W-1{1'b0}},
        1'b1} << len);
    end
  endfunction

  // ==========================================================
  // Declarations
  reg [`VLF_REG_W-1:0] state_ff;
  reg [`VLF_LEN_W-1:0] len_ff;
  reg [`VLF_CNT_W-1:0] load_cnt_ff;
  reg load_done_ff;
  reg load_short_ff;
  reg load_prev_ff;
  reg lock_ff;
  reg [`VLF_LEN_W-1:0] eff_len;
  reg [`VLF_REG_W-1:0] taps;
  reg [`VLF_REG_W-1:0] act_mask;
  reg fb_bit;
  reg out_bit;
  reg advance;
  reg [`VLF_CNT_W-1:0] nxt_load_cnt;
  wire [`VLF_REG_W-1:0] nxt_state;
  wire [`VLF_REG_W-1:0] shift_src;
  wire buf_ready;

  // ==========================================================
  // Length capture and feedback
  always @* begin
    // sample length at this edge
    // Length 0 would give one stage, which has no maximal sequence
    if (load) begin
      eff_len = len_ff;
    end else if (seq_len < `VLF_LEN_MIN) begin
      eff_len = `VLF_LEN_MIN;
    end else begin
      eff_len = seq_len;
    end
    taps = tap_mask(eff_len);
    act_mask = size_mask(eff_len);
    // XOR or XNOR chosen at build
    if (FB_XNOR == `VLF_FB_XNOR) begin
      fb_bit = ~(^(state_ff & taps));
    end else begin
      fb_bit = ^(state_ff & taps);
    end
    out_bit = state_ff[eff_len];
    // Generation waits for buffer room so no bit is dropped
    advance = ~load & buf_ready;
  end

  // ==========================================================
  // Shift register stages
  // load shifts seed_in
  assign shift_src[0] = load ? seed_in : fb_bit;
  genvar gi;
  generate
    for (gi = 1; gi < `VLF_REG_W; gi = gi + 1) begin : g_stage
      assign shift_src[gi] = state_ff[gi-1];
    end
  endgenerate
  // first edge after load starts generating
  // Stages above the active size keep shifting; they never reach output
  assign nxt_state = (load | advance) ? shift_src : state_ff;

  // ==========================================================
  // Load counter
  always @* begin
    if (~load) begin
      nxt_load_cnt = {`VLF_CNT_W{1'b0}};
    end else if (load_cnt_ff == `VLF_LOAD_CYC) begin
      nxt_load_cnt = load_cnt_ff;
    end else begin
      nxt_load_cnt = load_cnt_ff + {{`VLF_CNT_W-1{1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Registers
  // asynchronous active-high reset
  always @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      state_ff <= RST_SEED;
      len_ff <= `VLF_LEN_MIN;
      load_cnt_ff <= {`VLF_CNT_W{1'b0}};
      load_done_ff <= 1'b0;
      load_short_ff <= 1'b0;
      load_prev_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      len_ff <= eff_len;
      load_cnt_ff <= nxt_load_cnt;
      load_prev_ff <= load;
      // seed complete after 32 loading edges
      if (load & ~load_prev_ff) begin
        load_done_ff <= 1'b0;
      end else if (load & (nxt_load_cnt == `VLF_LOAD_CYC)) begin
        load_done_ff <= 1'b1;
      end
      // early release of load is flagged
      if (load & ~load_prev_ff) begin
        load_short_ff <= 1'b0;
      end else if (~load & load_prev_ff) begin
        load_short_ff <= (load_cnt_ff != `VLF_LOAD_CYC);
      end
      if (FB_XNOR == `VLF_FB_XNOR) begin
        lock_ff <= ((nxt_state & act_mask) == act_mask) & ~load;
      end else begin
        lock_ff <= ((nxt_state & act_mask) == `VLF_ZERO_REG) & ~load;
      end
    end
  end

  // ==========================================================
  // Output buffer
  // one sequence bit per advance
  // Loading flushes stale bits of the previous sequence
  vlf_skid #(
    .WIDTH(1)
  ) u_skid (
    .sys_clk(sys_clk),
    .arst(arst),
    .flush(load),
    .in_valid(advance),
    .in_ready(buf_ready),
    .in_data(out_bit),
    .out_valid(seq_valid),
    .out_ready(seq_ready),
    .out_data(seq_bit)
  );

  // reported size is the captured length plus one, so length 0 reports 2
  assign size_now = {1'b0, len_ff} + {{`VLF_SIZE_W-1{1'b0}}, 1'b1};
  assign load_done = load_done_ff;
  assign load_short = load_short_ff;
  assign lock_state = lock_ff;

endmodule

/* tb/vlf_lfsr_checker.sv */
// Port assertions for the variable length sequence generator
`timescale 1ns/1ps
module vlf_lfsr_checker (
  input wire sys_clk, // Clock
  input wire arst, // Reset, active high
  input wire [4:0] seq_len, // Size minus one
  input wire load, // Seed load
  input wire seed_in, // Seed bit
  input wire seq_valid, // Bit offered
  input wire seq_ready, // Bit taken
  input wire seq_bit, // Sequence bit
  input wire [5:0] size_now, // Active stages
  input wire load_done, // Full seed taken
  input wire load_short, // Seed cut short
  input wire lock_state // Lock-up value
);
  // ==========================================================
  // Load edge counter, saturating so long loads stay cheap
  reg [5:0] cnt_ff;
  wire [5:0] nxt_cnt = !load ? 6'h00 :
    (cnt_ff == 6'h21) ? cnt_ff : cnt_ff + 6'h01;
  always @(posedge sys_clk or posedge arst) begin
    if (arst)
      cnt_ff <= 6'h00;
    else
      cnt_ff <= nxt_cnt;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (arst);
  sequence s_load_end;
    !load && $past(load);
  endsequence
  // Buffer was flushed by load, so the first push shows one edge later
  sequence s_first_bit;
    !seq_valid ##1 seq_valid;
  endsequence
  a_size_follows: assert property (!load && !$past(arst) |=>
    size_now == ($past(seq_len) == 5'h00 ? 6'h02 :
    {1'b0, $past(seq_len)} + 6'h01))
    else $error("size does not follow length");
  a_size_held: assert property (load |=> $stable(size_now))
    else $error("size changed during load");
  a_size_range: assert property (size_now >= 6'h02 && size_now <= 6'h20)
    else $error("size out of range");
  a_load_done: assert property (load |=>
    load_done == ($past(cnt_ff) >= 6'h1f))
    else $error("load done flag wrong");
  a_short_load: assert property (s_load_end |=>
    load_short == ($past(cnt_ff) < 6'h20))
    else $error("short load flag wrong");
  a_bit_holds: assert property (seq_valid && !seq_ready && !load |=>
    seq_valid && $stable(seq_bit))
    else $error("bit lost under stall");
  a_load_quiet: assert property (load ##1 load |=> !seq_valid)
    else $error("bit offered during load");
  a_start_edge: assert property (s_load_end |-> s_first_bit)
    else $error("generation start latency wrong");
endmodule
bind vlf_lfsr vlf_lfsr_checker i_vlf_lfsr_checker (.*);

/* tb/vlf_sink.sv */
// Consumer model: takes sequence bits, scrambles them, stalls on request
`timescale 1ns/1ps
module vlf_sink (
  input wire sys_clk, // Clock
  input wire arst, // Reset, active high
  input wire seq_valid, // Bit offered
  input wire seq_bit, // Sequence bit
  input wire plain, // Data bit to scramble
  input wire pat, // Stall four of every eight cycles
  input wire clr, // Restart capture
  output reg seq_ready, // Take the bit
  output reg [63:0] got, // Taken bits, oldest high
  output reg [6:0] n // Bits taken, stops at 64
);
  reg [2:0] cyc;
  always @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      cyc <= 3'h0;
      got <= 64'h0;
      n <= 7'h00;
      seq_ready <= 1'b0;
    end else begin
      cyc <= cyc + 3'h1;
      seq_ready <= #1 !(pat && cyc[2]);
      if (clr)
        n <= 7'h00;
      else if (seq_valid && seq_ready && n < 7'h40) begin
        got <= {got[62:0], seq_bit ^ plain};
        n <= n + 7'h01;
      end
    end
  end
endmodule

/* tb/vlf_lfsr_bench.sv */
// Self-checking bench for the variable length sequence generator
`timescale 1ns/1ps
module vlf_lfsr_bench;
  typedef struct {logic [4:0] l; logic [31:0] m; logic [31:0] s;} vlf_row_t;
  vlf_row_t rows [9] = '{'{5'h01, 32'h3, 32'h9}, '{5'h02, 32'h6, 32'h5},
    '{5'h03, 32'hc, 32'h0}, '{5'h04, 32'h14, 32'h1b}, '{5'h06, 32'h60, 32'h55},
    '{5'h07, 32'hb8, 32'ha5}, '{5'h0f, 32'hd008, 32'h1234},
    '{5'h1f, 32'h80200003, 32'hdeadbeef}, '{5'h00, 32'h3, 32'h2}};
  reg sys_clk = 1'b0;
  reg arst = 1'b1;
  reg load = 1'b0;
  reg seed_in = 1'b0;
  reg pat = 1'b0;
  reg clr = 1'b0;
  reg plain = 1'b0;
  reg [4:0] seq_len = 5'h03;
  wire seq_valid, seq_ready, seq_bit, load_done, load_short, lock_state;
  wire [5:0] size_now;
  wire [63:0] got;
  wire [6:0] n;
  wire seq_valid_x, seq_ready_x, seq_bit_x, lock_x;
  wire [63:0] got_x;
  wire [6:0] n_x;
  logic [31:0] msk;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int r;
  vlf_lfsr i_vlf_lfsr (.sys_clk(sys_clk), .arst(arst), .seq_len(seq_len),
    .load(load), .seed_in(seed_in), .seq_valid(seq_valid),
    .seq_ready(seq_ready), .seq_bit(seq_bit), .size_now(size_now),
    .load_done(load_done), .load_short(load_short), .lock_state(lock_state));
  vlf_sink i_vlf_sink (.sys_clk(sys_clk), .arst(arst), .seq_valid(seq_valid),
    .seq_bit(seq_bit), .plain(plain), .pat(pat), .clr(clr),
    .seq_ready(seq_ready), .got(got), .n(n));
  // XNOR build shares clock, reset, length, load and seed inputs, with its own sink, so both feedback options run
  vlf_lfsr #(.FB_XNOR(1'b1)) i_vlf_lfsr_xn (.sys_clk(sys_clk), .arst(arst),
    .seq_len(seq_len), .load(load), .seed_in(seed_in),
    .seq_valid(seq_valid_x), .seq_ready(seq_ready_x), .seq_bit(seq_bit_x),
    .size_now(), .load_done(), .load_short(), .lock_state(lock_x));
  vlf_sink i_vlf_sink_xn (.sys_clk(sys_clk), .arst(arst),
    .seq_valid(seq_valid_x), .seq_bit(seq_bit_x), .plain(plain), .pat(pat),
    .clr(clr), .seq_ready(seq_ready_x), .got(got_x), .n(n_x));
  // ==========================================================
  // Clock, watchdog and shared tasks
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      give_verdict;
    end
  end
  task step;
    @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [63:0] a, input logic [63:0] e);
    n_checks++;
    if (a !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, a, e);
    end
  endtask
  task give_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Reference: output is last active stage, taps fold into stage 0
  function [63:0] model(input [4:0] len, input [31:0] m, input [31:0] s,
    input fbx);
    reg [31:0] st;
    int k;
    st = s;
    for (k = 0; k < 64; k++) begin
      model = {model[62:0], st[len == 5'h00 ? 5'h01 : len]};
      st = {st[30:0], fbx ^ (^(st & m))};
    end
  endfunction
  task load_seed(input [4:0] len, input [31:0] sd, input int cnt);
    int i;
    clr = 1'b1;
    load = 1'b1;
    for (i = 0; i < cnt; i++) begin
      seq_len = i == cnt - 1 ? len : ~len;
      seed_in = sd[31 - i];
      step;
    end
    load = 1'b0;
    clr = 1'b0;
  endtask
  // Seed toggles throughout so a leak into the register shows
  task run(input [4:0] len, input [31:0] m, input [31:0] s);
    int k;
    for (k = 0; k < 600 && (n < 7'h40 || n_x < 7'h40); k++) begin
      seed_in = ~seed_in;
      step;
    end
    chk(got, model(len, m, s, 1'b0) ^ {64{plain}});
    chk(got_x, model(len, m, s, 1'b1) ^ {64{plain}});
    chk(size_now, len == 5'h00 ? 6'h02 : {1'b0, len} + 6'h01);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) step;
    arst = 1'b0;
    chk(size_now, 6'h02);
    chk(seq_valid, 1'b0);
    run(5'h03, 32'hc, 32'h1);
    for (r = 0; r < 9; r++) begin
      pat = r[0];
      plain = r[1];
      load_seed(rows[r].l, rows[r].s, 32);
      chk(load_done, 1'b1);
      run(rows[r].l, rows[r].m, rows[r].s);
      // Length 0 runs as two stages, so the lock mask must follow
      msk = 32'hffffffff >> (31 - (rows[r].l == 5'h00 ? 1 : rows[r].l));
      chk(lock_state, (rows[r].s & msk) == 32'h0);
      chk(lock_x, (rows[r].s & msk) == msk);
    end
    load_seed(5'h03, 32'h0, 20);
    repeat (3) step;
    chk(load_short, 1'b1);
    chk(load_done, 1'b0);
    #3 arst = 1'b1;
    #1 chk(seq_valid, 1'b0);
    chk(size_now, 6'h02);
    give_verdict;
  end
endmodule
